// ===== design/alu8_core.sv
// 8-bit arithmetic and logic datapath with status flags
`timescale 1ns/1ps
module alu8_core
    import alu8_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // request from decoder
    input  wire alu8_req_s   i_req,
    // results to register file
    output alu8_res_s        o_res,
    output logic             o_busy,
    output logic [5:0]       o_flags
);

    alu8_state_e        state_ff;
    alu8_state_e        nxt_state;
    alu8_res_s          res_ff;
    alu8_res_s          nxt_res;
    logic [5:0]         flags_ff;
    logic [5:0]         nxt_flags;
    logic [15:0]        pair_ff;
    logic [7:0]         pimm_ff;
    logic               psub_ff;
    logic               busy_ff;

    wire logic          take    = i_req.valid && (state_ff == ALU8_ST_IDLE);
    wire logic          cin     = flags_ff[ALU8_F_C];
    wire logic [7:0]    b       = i_req.use_imm ? i_req.imm : i_req.source_operand;
    wire logic [7:0]    a       = i_req.dest;
    wire logic          is_addc = (i_req.op == ALU8_OP_ADDC);
    wire logic          is_subb = (i_req.op == ALU8_OP_SUBB);
    wire logic          is_add  = (i_req.op == ALU8_OP_ADD) || is_addc;
    wire logic          is_sub  = (i_req.op == ALU8_OP_SUB) || is_subb;
    wire logic          is_pair = (i_req.op == ALU8_OP_PADD) || (i_req.op == ALU8_OP_PSUB);
    wire logic          ci      = (is_addc || is_subb) & cin;

    // adder and subtractor with carry/borrow in
    wire logic [8:0]    sum9    = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    wire logic [8:0]    dif9    = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    wire logic [4:0]    hsum    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    wire logic [4:0]    hdif    = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    wire logic          vadd    = (a[7] == b[7]) && (sum9[7] != a[7]);
    wire logic          vsub    = (a[7] != b[7]) && (dif9[7] != a[7]);

    // logic unit
    wire logic [7:0]    lres    = (i_req.op == ALU8_OP_AND)  ? (a & b) :
                                  (i_req.op == ALU8_OP_XOR)  ? (a ^ i_req.source_operand) :
                                  (i_req.op == ALU8_OP_CLRM) ? (a & (ALU8_BYTE_ONES ^ i_req.imm)) :
                                  (i_req.op == ALU8_OP_SETM) ? (a | i_req.imm) :
                                  (a | b);
    wire logic [7:0]    r8      = is_add ? sum9[7:0] : (is_sub ? dif9[7:0] : lres);
    wire logic          v8      = is_add ? vadd : (is_sub ? vsub : 1'b0);
    wire logic          z8      = (r8 == ALU8_BYTE_ZERO);
    wire logic          n8      = r8[7];
    wire logic          c8      = is_add ? sum9[8] : (is_sub ? dif9[8] : cin);
    wire logic          h8      = is_add ? hsum[ALU8_HBIT] :
                                  (is_sub ? hdif[ALU8_HBIT] : flags_ff[ALU8_F_H]);

    // 16-bit pair step, second clock
    wire logic [16:0]   pimm17  = {9'h000, pimm_ff};
    wire logic [16:0]   p17     = psub_ff ? ({1'b0, pair_ff} - pimm17)
                                          : ({1'b0, pair_ff} + pimm17);
    wire logic [15:0]   r16     = p17[15:0];
    wire logic          pv      = psub_ff ? (pair_ff[15] & ~r16[15])
                                          : (~pair_ff[15] & r16[15]);
    wire logic          pn      = r16[15];
    wire logic          pz      = (r16 == ALU8_PAIR_ZERO);

    always_comb begin
        nxt_state = state_ff;
        nxt_res   = '0;
        nxt_flags = flags_ff;
        case (state_ff)
            ALU8_ST_IDLE: begin
                if (take && is_pair) begin
                    nxt_state = ALU8_ST_PAIR1;
                end else if (take) begin
                    nxt_res.wr8  = 1'b1;
                    nxt_res.res8 = r8;
                    nxt_flags[ALU8_F_Z] = z8;
                    nxt_flags[ALU8_F_N] = n8;
                    nxt_flags[ALU8_F_V] = v8;
                    nxt_flags[ALU8_F_S] = n8 ^ v8;
                    nxt_flags[ALU8_F_C] = c8;
                    nxt_flags[ALU8_F_H] = h8;
                end
            end
            ALU8_ST_PAIR1: begin
                nxt_state     = ALU8_ST_IDLE;
                nxt_res.wr16  = 1'b1;
                nxt_res.res16 = r16;
                nxt_flags[ALU8_F_Z] = pz;
                nxt_flags[ALU8_F_N] = pn;
                nxt_flags[ALU8_F_V] = pv;
                nxt_flags[ALU8_F_S] = pn ^ pv;
                nxt_flags[ALU8_F_C] = p17[16];
            end
            default: begin
                nxt_state = ALU8_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_ff <= ALU8_ST_IDLE;
            res_ff   <= '0;
            flags_ff <= '0;
            pair_ff  <= ALU8_PAIR_ZERO;
            pimm_ff  <= ALU8_BYTE_ZERO;
            psub_ff  <= 1'b0;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state == ALU8_ST_PAIR1);
            res_ff   <= nxt_res;
            flags_ff <= nxt_flags;
            if (take && is_pair) begin
                pair_ff <= i_req.pair;
                pimm_ff <= i_req.imm;
                psub_ff <= (i_req.op == ALU8_OP_PSUB);
            end
        end
    end

    assign o_res   = res_ff;
    assign o_flags = flags_ff;
    assign o_busy  = busy_ff;

    // checks
    logic               past_ok_ff;
    always_ff @(posedge i_core_clk) begin
        past_ok_ff <= i_rst_n;
    end

    add_result_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && is_add) |=> (o_res.wr8 && o_res.res8 == $past(sum9[7:0])))
        else $error("add result wrong");
    pair_two_clk_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_PADD) |=> !o_res.wr16 ##1 o_res.wr16)
        else $error("pair sum not in two clocks");
    sub_result_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_SUB) |=> (o_res.res8 == $past(a - b)))
        else $error("difference wrong");
    borrow_used_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && is_subb) |=> (o_res.res8 == $past(a - b - {7'h00, cin})))
        else $error("borrow not subtracted");
    pair_diff_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_PSUB) |=> ##1
        (o_res.res16 == $past(i_req.pair, 2) - {8'h00, $past(i_req.imm, 2)}))
        else $error("pair difference wrong");
    and_keeps_c_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_AND) |=> $stable(o_flags[ALU8_F_C]))
        else $error("and changed carry");
    xor_result_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_XOR) |=>
        (o_res.res8 == $past(a ^ i_req.source_operand) && !o_flags[ALU8_F_V]))
        else $error("xor wrong");
    set_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_SETM) |=> (o_res.res8 == $past(a | i_req.imm)))
        else $error("set mask wrong");
    clr_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_CLRM) |=> (o_res.res8 == $past(a & ~i_req.imm)))
        else $error("clear mask wrong");
    sign_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (past_ok_ff && (o_res.wr8 || o_res.wr16)) |->
        (o_flags[ALU8_F_S] == (o_flags[ALU8_F_N] ^ o_flags[ALU8_F_V])))
        else $error("sign flag wrong");
    pair_sum_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_PADD) |=> ##1
        (o_res.wr16 && o_res.res16 == $past(i_req.pair, 2) + {8'h00, $past(i_req.imm, 2)}))
        else $error("pair sum wrong");
    pdiff_two_clk_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_PSUB) |=> !o_res.wr16 ##1 o_res.wr16)
        else $error("pair difference not in two clocks");
    busy_refuse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_busy |=> (!o_res.wr8 && o_res.wr16 && !o_busy))
        else $error("request taken while busy");
    add_carry_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_ADD) |=>
        (o_flags[ALU8_F_C] == ($past(a) > (ALU8_BYTE_ONES - $past(b)))))
        else $error("add carry wrong");
    sub_borrow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_SUB) |=> (o_flags[ALU8_F_C] == ($past(a) < $past(b))))
        else $error("subtract borrow wrong");
    zero_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_res.wr8 |-> (o_flags[ALU8_F_Z] == (o_res.res8 == ALU8_BYTE_ZERO)))
        else $error("zero flag wrong");
    neg_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_res.wr8 |-> (o_flags[ALU8_F_N] == o_res.res8[ALU8_W-1]))
        else $error("negative flag wrong");
    pair_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_res.wr16 |-> (o_flags[ALU8_F_Z] == (o_res.res16 == ALU8_PAIR_ZERO)))
        else $error("pair zero flag wrong");
    and_clears_v_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_AND) |=> !o_flags[ALU8_F_V])
        else $error("and left overflow set");
    or_keeps_c_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && i_req.op == ALU8_OP_OR) |=>
        ($stable(o_flags[ALU8_F_C]) && o_res.res8 == $past(a | b)))
        else $error("or wrong");
    pair_keeps_h_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (take && is_pair) |=> ##1 $stable(o_flags[ALU8_F_H]))
        else $error("pair op changed half carry");
    reset_clear_a: assert property (@(posedge i_core_clk)
        (!i_rst_n) |=> (o_res == '0 && o_flags == '0 && !o_busy))
        else $error("outputs not cleared by reset");

endmodule

// ===== design/alu8_pkg.sv
// package for the 8-bit arithmetic and logic datapath
package alu8_pkg;

    localparam int unsigned ALU8_W     = 8;
    localparam int unsigned ALU8_PW    = 16;
    localparam int unsigned ALU8_IMMW  = 6;
    localparam int unsigned ALU8_HBIT  = 4;
    localparam int unsigned ALU8_CLK_MHZ = 250;

    localparam logic [7:0]  ALU8_BYTE_ZERO = 8'h00;
    localparam logic [7:0]  ALU8_BYTE_ONES = 8'hff;
    localparam logic [15:0] ALU8_PAIR_ZERO = 16'h0000;

    // status flag positions in the 6-bit flag vector: {s, v, n, z, c, h}
    localparam int unsigned ALU8_F_H = 0;
    localparam int unsigned ALU8_F_C = 1;
    localparam int unsigned ALU8_F_Z = 2;
    localparam int unsigned ALU8_F_N = 3;
    localparam int unsigned ALU8_F_V = 4;
    localparam int unsigned ALU8_F_S = 5;
    localparam int unsigned ALU8_NFLAGS = 6;

    typedef enum logic [3:0] {
        ALU8_OP_ADD   = 4'h0,
        ALU8_OP_ADDC  = 4'h1,
        ALU8_OP_SUB   = 4'h2,
        ALU8_OP_SUBB  = 4'h3,
        ALU8_OP_AND   = 4'h4,
        ALU8_OP_OR    = 4'h5,
        ALU8_OP_XOR   = 4'h6,
        ALU8_OP_SETM  = 4'h7,
        ALU8_OP_CLRM  = 4'h8,
        ALU8_OP_PADD  = 4'h9,
        ALU8_OP_PSUB  = 4'ha
    } alu8_op_e;

    typedef enum logic [1:0] {
        ALU8_ST_IDLE  = 2'b00,
        ALU8_ST_PAIR1 = 2'b01
    } alu8_state_e;

    // request from the instruction decoder
    typedef struct packed {
        logic        valid;
        alu8_op_e    op;
        logic        use_imm;
        logic [7:0]  dest;
        logic [7:0]  source_operand;
        logic [7:0]  imm;
        logic [15:0] pair;
    } alu8_req_s;

    // answer towards the register file
    typedef struct packed {
        logic        wr8;
        logic [7:0]  res8;
        logic        wr16;
        logic [15:0] res16;
    } alu8_res_s;

endpackage

// ===== tb/alu8_partner.sv
// decoder-side model presenting requests to the datapath
`timescale 1ns/1ps
module alu8_partner
    import alu8_pkg::*;
(
    // clock
    input  wire logic i_core_clk,
    // request out
    output alu8_req_s o_req
);
    localparam int RW = $bits(alu8_req_s);

    initial o_req = '0;

    // released lines show the inverse of the last request
    task automatic idle(input alu8_req_s r);
        o_req <= {1'b0, ~r[RW-2:0]};
    endtask

    // one request; poke holds a stray request up in the busy cycle
    task automatic send(input alu8_req_s r, input logic poke);
        o_req <= r;
        @(posedge i_core_clk);
        if (r.op == ALU8_OP_PADD || r.op == ALU8_OP_PSUB) begin
            if (poke) begin
                o_req.op <= ALU8_OP_ADD;
            end else begin
                idle(r);
            end
            @(posedge i_core_clk);
        end
    endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the arithmetic and logic datapath
`timescale 1ns/1ps
module tb_top;
    import alu8_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    alu8_req_s   req;
    alu8_res_s   res;
    logic        busy;
    logic [5:0]  flags;
    logic [5:0]  fm = 6'h00;
    logic        busy_exp = 1'b0;
    logic [22:0] exp_q[$];
    logic [31:0] rnd;
    logic [31:0] rnd2;
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    integer      seed = 94;

    always #2 i_core_clk = ~i_core_clk;

    alu8_core alu8_core_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(req),
                           .o_res(res), .o_busy(busy), .o_flags(flags));
    alu8_partner alu8_partner_i (.i_core_clk(i_core_clk), .o_req(req));

    task automatic check(input logic [22:0] seen, input logic [22:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // works out result and flags, notes them, then sends the request
    task automatic run(input alu8_op_e op, input logic u, input logic [7:0] a, s, k,
                       input logic [15:0] p, input logic poke);
        logic [7:0]  b;
        logic [8:0]  w;
        logic [16:0] x;
        logic        ci;
        logic        h;
        logic        c;
        logic        v;
        logic        n;
        logic        pr;
        b = u ? k : s;
        ci = (op == ALU8_OP_ADDC || op == ALU8_OP_SUBB) ? fm[ALU8_F_C] : 1'b0;
        h = fm[ALU8_F_H];
        c = fm[ALU8_F_C];
        v = 1'b0;
        pr = (op == ALU8_OP_PADD || op == ALU8_OP_PSUB);
        w = 9'h000;
        x = {1'b0, p} + k;
        case (op)
            ALU8_OP_ADD, ALU8_OP_ADDC: begin
                w = {1'b0, a} + b + ci;
                h = (a[3:0] + b[3:0] + ci) > 15;
                v = (a[7] == b[7]) && (w[7] != a[7]);
                c = w[8];
            end
            ALU8_OP_SUB, ALU8_OP_SUBB: begin
                w = {1'b0, a} - b - ci;
                h = ({1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, ci}));
                v = (a[7] != b[7]) && (w[7] != a[7]);
                c = w[8];
            end
            ALU8_OP_AND:  w = {1'b0, a & b};
            ALU8_OP_OR:   w = {1'b0, a | b};
            ALU8_OP_XOR:  w = {1'b0, a ^ s};
            ALU8_OP_SETM: w = {1'b0, a | k};
            ALU8_OP_CLRM: w = {1'b0, a & ~k};
            ALU8_OP_PSUB: begin
                x = {1'b0, p} - k;
                v = p[15] & ~x[15];
                c = x[16];
            end
            default: begin
                v = ~p[15] & x[15];
                c = x[16];
            end
        endcase
        x = pr ? {1'b0, x[15:0]} : {9'h000, w[7:0]};
        n = pr ? x[15] : x[7];
        fm = {n ^ v, v, n, x[15:0] == 16'h0000, c, h};
        exp_q.push_back({pr, x[15:0], fm});
        alu8_partner_i.send('{1'b1, op, u, a, s, k, p}, poke);
    endtask

    // busy is expected for the clock after a pair request is taken
    always @(posedge i_core_clk) begin
        busy_exp <= i_rst_n && req.valid && !busy_exp &&
                    (req.op == ALU8_OP_PADD || req.op == ALU8_OP_PSUB);
    end

    always @(negedge i_core_clk) begin
        check(23'(busy), 23'(busy_exp));
        if (i_rst_n && (res.wr8 || res.wr16)) begin
            check({res.wr16, res.wr16 ? res.res16 : {8'h00, res.res8}, flags},
                  exp_q.size() > 0 ? exp_q.pop_front() : 23'hx);
        end
    end

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge i_core_clk);
        check({res.wr8 | res.wr16, res.res16, flags}, 23'h0);
        i_rst_n <= 1'b1;
        run(ALU8_OP_ADD, 1'b0, 8'h7f, 8'h01, 8'h00, 16'h0000, 1'b0);
        run(ALU8_OP_ADD, 1'b1, 8'hff, 8'h00, 8'h01, 16'h0000, 1'b0);
        run(ALU8_OP_SUBB, 1'b1, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        run(ALU8_OP_PADD, 1'b0, 8'h00, 8'h00, 8'h01, 16'hffff, 1'b1);
        run(ALU8_OP_PSUB, 1'b0, 8'h00, 8'h00, 8'h01, 16'h0000, 1'b0);
        run(ALU8_OP_PADD, 1'b0, 8'h00, 8'h00, 8'h3f, 16'h7fc1, 1'b0);
        for (int i = 0; i < 400; i++) begin
            rnd = $random(seed);
            rnd2 = $random(seed);
            run(alu8_op_e'(rnd[31:28] % 4'hb), rnd[24], rnd[7:0], rnd[15:8], rnd[23:16],
                rnd2[15:0], rnd[25]);
        end
        alu8_partner_i.idle(req);
        repeat (4) @(posedge i_core_clk);
        check(23'(exp_q.size()), 23'h0);
        end_sim();
    end
endmodule
